/* logic/tlsa_alert.sv */
/*
  Conversion sequencing and alert logic of the sensor: limit checks on every completed
  result, slew checks on continuous-mode results after the first, sticky flags and the alert output.
  Assumes configuration and status-read strobe come from the serial
  register front end on the same clock; sample data arrives on that clock.
*/
// Operation
// R1: limit check can be disabled entirely
// R2: compare each completed result against both limits
// R3: alert when result leaves limit window
// R4: slew threshold is unsigned
// R5: rise equals current minus previous result
// R6: rise above threshold sets slew bits
// R7: slew check only in continuous mode
// R8: temperature decreases never raise slew warning
// R9: continuous, one-shot and shutdown modes
// R10: host waits 0.5 ms after power
// R11: host keeps select high 100 ns
// R12: interrupt mode: status read clears flags
// R13: mode bit 0 continuous, 1 shutdown
// R14: skip slew on first conversion
// R15: previous result updated after every conversion
module tlsa_alert
  import tlsa_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYCLES
) (
  // clock and reset
  input  wire  logic              clk,
  input  wire  logic              rst_b,
  // configuration and host reads
  input  wire  tlsa_cfg_t         cfg,
  input  wire  logic              status_rd,
  // converter sample
  input  wire  logic [TEMP_W-1:0] sample,
  // results
  output logic [TEMP_W-1:0]       temp_result,
  output tlsa_flags_t             flags,
  output logic                    data_ready,
  output tlsa_mode_t              mode,
  output logic                    alert
);

  // signed comparison of two results; both limit checks share it
  function automatic logic above(input logic [TEMP_W-1:0] a,
                                 input logic [TEMP_W-1:0] b);
    return $signed(a) > $signed(b);
  endfunction : above

  // a fall leaves the sign bit set and can never trip the check;
  // the threshold is taken unsigned, zero-extended against the rise
  function automatic logic slew_over(input logic signed [TEMP_W:0] d,
                                     input logic [TEMP_W-1:0]      lim);
    return !d[TEMP_W] && (d[TEMP_W-1:0] > lim); // R4 R8
  endfunction : slew_over

  // sequencer state
  logic [31:0]            cnt;
  logic [31:0]            next_cnt;
  tlsa_mode_t             next_mode;
  logic                   os_arm;
  logic                   next_os_arm;
  logic                   done;
  logic                   stop;

  // result state
  logic [TEMP_W-1:0]      next_temp;
  logic [TEMP_W-1:0]      prev;
  logic [TEMP_W-1:0]      next_prev;
  logic                   prev_ok;
  logic                   next_prev_ok;
  logic                   next_ready;

  // flag state
  tlsa_flags_t            next_flags;
  logic                   next_alert;
  logic                   clr;
  logic                   slew_trip;
  logic signed [TEMP_W:0] rise;

  // a status read only clears in interrupt mode
  assign clr = status_rd & cfg.int_mode; // R12

  // one extra bit keeps the full span of a 14-bit difference
  assign rise = $signed({sample[TEMP_W-1], sample}) -
                $signed({prev[TEMP_W-1], prev}); // R5

  // no previous result after reset, shutdown or one-shot: no slew check
  assign slew_trip = (mode == TLSA_CONT) && prev_ok && // R7 R14
                     slew_over(rise, cfg.slew_limit);

  // sequencer: conversion timing and operating mode
  always_comb begin
    next_cnt    = cnt;
    next_mode   = mode;
    next_os_arm = os_arm & cfg.one_shot;
    done        = 1'b0;
    stop        = 1'b0;
    // a fresh one-shot request restarts the conversion, dropping any partial
    if (cfg.one_shot && !os_arm) begin
      next_mode   = TLSA_ONESHOT; // R9
      next_cnt    = 32'h0;
      next_os_arm = 1'b1;
    end else if (mode != TLSA_ONESHOT && cfg.shutdown) begin
      // a conversion cut by shutdown is thrown away, never reported
      next_mode = TLSA_SHUTDOWN; // R13
      next_cnt  = 32'h0;
      stop      = 1'b1;
    end else if (mode == TLSA_SHUTDOWN) begin
      next_mode = TLSA_CONT; // R13
    end else if (cnt == 32'(CONV_CYC - 1)) begin
      done     = 1'b1;
      next_cnt = 32'h0;
      if (mode == TLSA_ONESHOT) begin
        // one-shot falls back to shutdown; the host drops its request
        next_mode = TLSA_SHUTDOWN; // R9
      end
    end else begin
      next_cnt = cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt    <= 32'h0;
      mode   <= TLSA_CONT;
      os_arm <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      mode   <= next_mode;
      os_arm <= next_os_arm;
    end
  end

  // results: last value, previous value for the slew check, ready bit
  always_comb begin
    next_temp    = temp_result;
    next_prev    = prev;
    next_prev_ok = prev_ok;
    next_ready   = data_ready;
    if (clr) begin
      next_ready = 1'b0;
    end
    if (stop) begin
      next_prev_ok = 1'b0;
    end
    // a conversion ending on the read edge still reports: set wins
    if (done) begin
      next_temp    = sample;
      next_ready   = 1'b1;
      next_prev    = sample; // R15
      next_prev_ok = (mode != TLSA_ONESHOT); // R14
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      temp_result <= '0;
      prev        <= '0;
      prev_ok     <= 1'b0;
      data_ready  <= 1'b0;
    end else begin
      temp_result <= next_temp;
      prev        <= next_prev;
      prev_ok     <= next_prev_ok;
      data_ready  <= next_ready;
    end
  end

  // sticky flags and the alert output
  always_comb begin
    next_flags = flags;
    if (clr) begin
      next_flags.high_flag = 1'b0; // R12
      next_flags.low_flag  = 1'b0;
      next_flags.slew_flag = 1'b0;
    end
    if (done) begin
      if (cfg.limit_en) begin // R1
        if (above(sample, cfg.high_limit)) begin // R2
          next_flags.high_flag = 1'b1;
        end
        if (above(cfg.low_limit, sample)) begin // R2
          next_flags.low_flag = 1'b1;
        end
      end
      // slew_status tracks only the latest check, never sticky
      next_flags.slew_status = slew_trip;
      if (slew_trip) begin
        next_flags.slew_flag = 1'b1; // R6
      end
    end
    // alert is taken from the next flags so both change on one edge
    next_alert = next_flags.high_flag | next_flags.low_flag |
                 next_flags.slew_flag; // R3
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flags <= '0;
      alert <= 1'b0;
    end else begin
      flags <= next_flags;
      alert <= next_alert;
    end
  end

endmodule : tlsa_alert

/* logic/tlsa_pkg.sv */
/*
  Package for the temperature limit and slew alert block: widths, reset
  values, mode enumeration and the packed carriers of the block.
  Assumes a 100 MHz system clock.
*/
package tlsa_pkg;

  localparam int TEMP_W = 14;

  localparam logic [TEMP_W-1:0] RST_LOW_LIMIT  = 14'h2000;
  localparam logic [TEMP_W-1:0] RST_HIGH_LIMIT = 14'h1FFF;
  localparam logic [TEMP_W-1:0] RST_SLEW_LIMIT = 14'h0000;

  localparam int CLK_MHZ = 100;
  localparam int CONV_TIME_US = 6000;
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    TLSA_CONT,
    TLSA_ONESHOT,
    TLSA_SHUTDOWN
  } tlsa_mode_t;

  typedef struct packed {
    logic              limit_en;
    logic              shutdown;
    logic              one_shot;
    logic              int_mode;
    logic [TEMP_W-1:0] low_limit;
    logic [TEMP_W-1:0] high_limit;
    logic [TEMP_W-1:0] slew_limit;
  } tlsa_cfg_t;

  typedef struct packed {
    logic high_flag;
    logic low_flag;
    logic slew_flag;
    logic slew_status;
  } tlsa_flags_t;

endpackage : tlsa_pkg

/* tb/tlsa_alert_chk.sv */
/* port checker of the alert block
   bound from the bench; CONV_CYC does not enter any property */
module tlsa_alert_chk
  import tlsa_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire tlsa_cfg_t         cfg,
  input wire logic              status_rd,
  input wire logic [TEMP_W-1:0] temp_result,
  input wire tlsa_flags_t       flags,
  input wire tlsa_mode_t        mode,
  input wire logic              alert
);
  timeunit 1ns; timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_hi; $rose(flags.high_flag) |->
    $signed(temp_result) > $signed($past(cfg.high_limit)); endproperty
  a_hi: assert property (p_hi) else $error("high flag");
  property p_lo; $rose(flags.low_flag) |-> $past(cfg.limit_en) &&
    $signed(temp_result) < $signed($past(cfg.low_limit)); endproperty
  a_lo: assert property (p_lo) else $error("low flag");
  property p_sl; $rose(flags.slew_flag) |-> int'($signed(temp_result)) >
    int'($signed($past(temp_result))) + int'($past(cfg.slew_limit));
  endproperty
  a_sl: assert property (p_sl) else $error("slew flag");
  property p_sm; $rose(flags.slew_flag) |-> $past(mode) == TLSA_CONT;
  endproperty
  a_sm: assert property (p_sm) else $error("slew mode");
  property p_cl; $past(status_rd) && $past(cfg.int_mode) &&
    $stable(temp_result) |-> !flags.high_flag && !flags.low_flag; endproperty
  a_cl: assert property (p_cl) else $error("clear");
  property p_kp; $past(flags.low_flag) && !$past(status_rd) |->
    flags.low_flag; endproperty
  a_kp: assert property (p_kp) else $error("sticky");
  property p_sd; $past(cfg.shutdown) && $past(cfg.shutdown, 2) |->
    mode != TLSA_CONT; endproperty
  a_sd: assert property (p_sd) else $error("shutdown");
  property p_al; !(flags.high_flag | flags.low_flag | flags.slew_flag) [*2]
    |-> !alert; endproperty
  a_al: assert property (p_al) else $error("alert");
endmodule : tlsa_alert_chk

/* tb/tlsa_host.sv */
/* host side: turns a read request into one status read pulse
   assumes requests are level and last one cycle */
module tlsa_host #(parameter int INIT = 20) (
  input  wire logic clk,
  input  wire logic rd_req,
  output logic      status_rd = 1'b0
);
  timeunit 1ns; timeprecision 1ns;
  int   n = 0;
  logic q = 1'b0;
  always @(posedge clk) begin
    n <= n + 1;
    q <= rd_req;
    status_rd <= rd_req && !q && n >= INIT;
  end
endmodule : tlsa_host

/* tb/tlsa_alert_bench.sv */
/* bench of the alert block: reference model, host model, watchdog
   assumes conversions every 8 cycles from reset release */
module tlsa_alert_bench
  import tlsa_pkg::*;
;
  timeunit 1ns; timeprecision 1ns;
  logic clk = 0, rst_b = 0, rd_req = 0, status_rd, data_ready, alert;
  logic [TEMP_W-1:0] sample = '0, temp_result, last = '0;
  tlsa_cfg_t cfg = '0;
  tlsa_flags_t flags;
  tlsa_mode_t mode;
  // host start-up wait after power: 0.5 ms in 10 ns cycles
  localparam int INIT_CYC = 50000;
  int n_errors = 0, tests_run = 0, v, h = 0, l = 0, s = 0, ss = 0, r = 0;
  int hist[$];
  tlsa_alert #(.CONV_CYC(8)) tlsa_alert_i (.clk, .rst_b, .cfg, .status_rd,
    .sample, .temp_result, .flags, .data_ready, .mode, .alert);
  tlsa_host #(.INIT(INIT_CYC)) tlsa_host_i (.clk, .rd_req, .status_rd);
  initial forever #5 clk = ~clk;
  task conclude;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task chk(input logic [TEMP_W-1:0] g, input logic [TEMP_W-1:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task chk_st(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_st
  initial begin
    #600us;
    n_errors++;
    conclude;
  end
  initial begin
    void'($urandom(63));
    cfg.high_limit = 14'h0400;
    cfg.low_limit  = 14'h3C00;
    repeat (20) @(posedge clk);
    #1 rst_b = 1;
    // a multiple of the conversion period keeps the bench in phase
    repeat (INIT_CYC) @(posedge clk);
    for (int i = 0; i < 40; i++) begin
      repeat (2) @(posedge clk);
      #1;
      if (!cfg.shutdown) begin
        v = $signed(sample);
        if (cfg.limit_en) begin
          h |= v > $signed(cfg.high_limit);
          l |= v < $signed(cfg.low_limit);
        end
        ss = hist.size() > 0 && v - hist[$] > int'(cfg.slew_limit);
        s |= ss;
        hist.push_back(v);
        last = sample;
        r = 1;
      end
      chk(temp_result, last);
      chk_st({flags, alert, data_ready, mode}, {h[0], l[0], s[0], ss[0],
        |{h[0], l[0], s[0]}, r[0],
        cfg.shutdown ? TLSA_SHUTDOWN : TLSA_CONT});
      sample = 14'($urandom);
      cfg.limit_en = 1'($urandom);
      cfg.int_mode = 1'($urandom);
      cfg.slew_limit = 14'($urandom_range(0, 3000));
      cfg.shutdown = i >= 36;
      rd_req = 1'($urandom);
      // a read lands well clear of the next conversion edge
      if (rd_req && cfg.int_mode) begin
        {h, l, s} = '0;
        r = 0;
      end
      @(posedge clk);
      #1 rd_req = 0;
      repeat (5) @(posedge clk);
    end
    // one-shot from shutdown: a single conversion, then shutdown again
    #1 sample = 14'($urandom);
    cfg.one_shot = 1'b1;
    repeat (10) @(posedge clk);
    #1 v = $signed(sample);
    if (cfg.limit_en) begin
      h |= v > $signed(cfg.high_limit);
      l |= v < $signed(cfg.low_limit);
    end
    chk(temp_result, sample);
    chk_st({flags, alert, data_ready, mode}, {h[0], l[0], s[0], 1'b0,
      |{h[0], l[0], s[0]}, 1'b1, TLSA_SHUTDOWN});
    conclude;
  end
endmodule : tlsa_alert_bench
bind tlsa_alert tlsa_alert_chk chk_i (.*);
